//--- sie_pkg.sv
// shared constants and types of the status indicator encoder
package sie_pkg;
    // register byte offsets on the wishbone slave
    localparam logic [7:0] SIE_REG_CTRL   = 8'h00;
    localparam logic [7:0] SIE_REG_DIV    = 8'h04;
    localparam logic [7:0] SIE_REG_ENCL   = 8'h08;
    localparam logic [7:0] SIE_REG_EVCNT  = 8'h0C;
    localparam logic [7:0] SIE_REG_LAMP   = 8'h10;
    localparam logic [7:0] SIE_REG_DISP   = 8'h14;
    localparam logic [7:0] SIE_REG_EVT0   = 8'h20;
    // control register fields
    localparam int SIE_CTRL_BOOT_DONE = 0;
    localparam int SIE_CTRL_BOOT_ERR  = 1;
    localparam int SIE_CTRL_CODE_LSB  = 8;
    localparam logic [31:0] SIE_CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] SIE_ENCL_RST  = 32'h0000_0000;
    localparam logic [31:0] SIE_EVCNT_RST = 32'h0000_0001;
    // event entry fields: category in low byte, detail in next byte
    localparam int SIE_EVT_CAT_LSB = 0;
    localparam int SIE_EVT_DET_LSB = 8;
    // timing
    localparam int SIE_CLK_MHZ       = 100;
    localparam int SIE_FLASH_HALF_MS = 250;
    localparam int SIE_FLASH_CYCLES  = SIE_FLASH_HALF_MS * 1000 * SIE_CLK_MHZ;
    localparam int SIE_HOLD_TICKS    = 4;
    // segment patterns, bit order gfedcba
    localparam logic [6:0] SIE_SEG_DASH  = 7'h40;
    localparam logic [6:0] SIE_SEG_BLANK = 7'h00;

    typedef enum {SIE_SQ_CAT, SIE_SQ_DET, SIE_SQ_DELIM, SIE_SQ_BLANK} sie_seq_t;

    // steady when link, flashing when busy, dark without link
    function automatic logic sie_lamp(input logic link, input logic busy, input logic ph);
        sie_lamp = link & (busy ? ph : 1'b1);
    endfunction

    // hex nibble to seven segments
    function automatic logic [6:0] sie_seg(input logic [3:0] n);
        case (n)
            4'h0: sie_seg = 7'h3F;
            4'h1: sie_seg = 7'h06;
            4'h2: sie_seg = 7'h5B;
            4'h3: sie_seg = 7'h4F;
            4'h4: sie_seg = 7'h66;
            4'h5: sie_seg = 7'h6D;
            4'h6: sie_seg = 7'h7D;
            4'h7: sie_seg = 7'h07;
            4'h8: sie_seg = 7'h7F;
            4'h9: sie_seg = 7'h6F;
            4'hA: sie_seg = 7'h77;
            4'hB: sie_seg = 7'h7C;
            4'hC: sie_seg = 7'h39;
            4'hD: sie_seg = 7'h5E;
            4'hE: sie_seg = 7'h79;
            default: sie_seg = 7'h71;
        endcase
    endfunction
endpackage

//--- sie_tick_gen.sv
// flash phase and hold tick divider
`timescale 1ns/10ps
`default_nettype none
module sie_tick_gen
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // half flash period in clock cycles
    input  wire logic [31:0] div_count,
    // outputs
    output logic             tick,
    output logic             flash_phase
);
    logic [31:0] cnt_r;
    wire         wrap = (cnt_r >= div_count - 32'h1) | (div_count == 32'h0);

    // one divider feeds every flash and every hold time
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_r       <= 32'h0;
            tick        <= 1'b0;
            flash_phase <= 1'b0;
        end
        else
        begin
            cnt_r <= wrap ? 32'h0 : cnt_r + 32'h1;
            tick  <= wrap;
            if (wrap)
                flash_phase <= ~flash_phase;
        end
    end
endmodule // sie_tick_gen
`default_nettype wire

//--- sie_top.sv
// status indicator encoder: lamps, numeric display and wishbone registers
//
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sie_top
#(
    parameter int N_ISCSI    = 4,
    parameter int N_FC       = 4,
    parameter int N_DRV      = 12,
    parameter int N_EVT      = 8,
    parameter int FLASH_DIV  = sie_pkg::SIE_FLASH_CYCLES
)
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rstn,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    // management ethernet and controller status
    input  wire logic                 mgmt_link_up,
    input  wire logic                 mgmt_gig,
    input  wire logic                 mgmt_traffic,
    input  wire logic                 sas_link_problem,
    input  wire logic                 sas_link_up,
    input  wire logic                 sas_traffic,
    input  wire logic                 cache_backup_en,
    input  wire logic                 cache_has_data,
    input  wire logic                 cache_offload,
    input  wire logic                 ctrl_fault,
    input  wire logic                 io_active,
    input  wire logic                 batt_full,
    input  wire logic                 batt_charging,
    input  wire logic                 batt_no_hold,
    // host port adapters
    input  wire logic [N_ISCSI-1:0]   iscsi_link_up,
    input  wire logic [N_ISCSI-1:0]   iscsi_gig,
    input  wire logic [N_ISCSI-1:0]   iscsi_traffic,
    input  wire logic [N_FC-1:0]      fc_module_ok,
    input  wire logic [2*N_FC-1:0]    fc_rate,
    input  wire logic                 tengig_link_up,
    input  wire logic                 tengig_rate_10g,
    input  wire logic                 tengig_acquiring,
    input  wire logic                 tengig_traffic,
    // drives and enclosure
    input  wire logic [N_DRV-1:0]     drive_active,
    input  wire logic [N_DRV-1:0]     drive_failed,
    input  wire logic [N_DRV-1:0]     drive_rebuild,
    input  wire logic                 overtemp,
    input  wire logic                 psu_fault,
    input  wire logic                 enclosure_service_module_fault,
    input  wire logic                 enclosure_service_module_link_ok,
    // controller lamps
    output logic                      mgmt_speed_led,
    output logic                      mgmt_act_led,
    output logic                      sas_service_led,
    output logic                      sas_link_led,
    output logic                      cache_led,
    output logic                      ctrl_fault_led,
    output logic                      remove_ok_led,
    output logic                      batt_charge_led,
    output logic                      batt_fault_led,
    // host port lamps
    output logic [N_ISCSI-1:0]        iscsi_act_led,
    output logic [N_ISCSI-1:0]        iscsi_speed_led,
    output logic [N_FC-1:0]           fc_2g_led,
    output logic [N_FC-1:0]           fc_4g_led,
    output logic                      tengig_rate_led,
    output logic                      tengig_act_led,
    // front lamps
    output logic [N_DRV-1:0]          drive_act_led,
    output logic [N_DRV-1:0]          drive_status_led,
    output logic                      overtemp_led,
    output logic                      sys_error_led,
    output logic                      encl_link_fault_led,
    output logic                      encl_link_up_led,
    // numeric display
    output logic                      diag_led,
    output logic                      heartbeat_led,
    output logic [6:0]                seg_tens,
    output logic [6:0]                seg_ones
);
    import sie_pkg::*;

    localparam int EW = $clog2(N_EVT);

    // registers
    logic [31:0]      ctrl_r;
    logic [31:0]      div_r;
    logic [31:0]      encl_r;
    logic [31:0]      evcnt_r;
    logic [15:0]      evt_r [N_EVT];
    logic             tick;
    logic             ph;
    sie_seq_t         seq_r;
    sie_seq_t         seq_nxt;
    logic [EW-1:0]    idx_r;
    logic [EW-1:0]    idx_nxt;
    logic [2:0]       hold_r;

    sie_tick_gen u_tick
    (
        .sys_clk     (sys_clk),
        .rstn        (rstn),
        .div_count   (div_r),
        .tick        (tick),
        .flash_phase (ph)
    );

    // bus decode
    wire        wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wb_wr    = wb_req & wb_we_i;
    wire [31:0] sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                            {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire        evt_hit  = (wb_adr_i >= SIE_REG_EVT0)
                         & (wb_adr_i < SIE_REG_EVT0 + 8'(4 * N_EVT))
                         & (wb_adr_i[1:0] == 2'b00);
    wire [7:0]  evt_off  = wb_adr_i - SIE_REG_EVT0;
    wire [EW-1:0] evt_ix = evt_off[EW+1:2];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    // mode decode
    wire boot_done = ctrl_r[SIE_CTRL_BOOT_DONE];
    wire boot_err  = ctrl_r[SIE_CTRL_BOOT_ERR];
    wire [7:0] boot_code = ctrl_r[SIE_CTRL_CODE_LSB +: 8];
    wire running   = boot_done & ~boot_err;
    wire [EW:0] ev_n = (evcnt_r == 32'h0) ? (EW+1)'(1)
                     : (evcnt_r > 32'(N_EVT)) ? (EW+1)'(N_EVT) : evcnt_r[EW:0];
    wire last_ev   = ({1'b0, idx_r} + (EW+1)'(1)) >= ev_n;
    wire hold_end  = tick & (hold_r == 3'(SIE_HOLD_TICKS - 1));

    // error sequence: category, detail, delimiter between pairs, blank, repeat
    always_comb
    begin
        seq_nxt = seq_r;
        idx_nxt = idx_r;
        if (!boot_err)
        begin
            seq_nxt = SIE_SQ_CAT;
            idx_nxt = '0;
        end
        else if (hold_end)
        begin
            case (seq_r)
                SIE_SQ_CAT:   seq_nxt = SIE_SQ_DET;
                SIE_SQ_DET:   seq_nxt = last_ev ? SIE_SQ_BLANK : SIE_SQ_DELIM;
                SIE_SQ_DELIM:
                begin
                    seq_nxt = SIE_SQ_CAT;
                    idx_nxt = idx_r + EW'(1);
                end
                SIE_SQ_BLANK:
                begin
                    seq_nxt = SIE_SQ_CAT;
                    idx_nxt = '0;
                end
                default:      seq_nxt = SIE_SQ_CAT;
            endcase
        end
    end

    // display content
    wire [15:0] cur_evt  = evt_r[idx_r];
    wire [7:0]  show_val = running ? encl_r[7:0]
                         : ~boot_err ? boot_code
                         : (seq_r == SIE_SQ_CAT) ? cur_evt[SIE_EVT_CAT_LSB +: 8]
                         : cur_evt[SIE_EVT_DET_LSB +: 8];
    wire        dash     = boot_err & (seq_r == SIE_SQ_DELIM);
    wire        blank    = boot_err & (seq_r == SIE_SQ_BLANK);
    wire [6:0]  tens_nxt = blank ? SIE_SEG_BLANK : dash ? SIE_SEG_DASH
                         : sie_seg(show_val[7:4]);
    wire [6:0]  ones_nxt = blank ? SIE_SEG_BLANK : dash ? SIE_SEG_DASH
                         : sie_seg(show_val[3:0]);

    // per port lamp decode
    wire [N_ISCSI-1:0] iscsi_act_nxt;
    wire [N_FC-1:0]    fc2_nxt;
    wire [N_FC-1:0]    fc4_nxt;
    wire [N_DRV-1:0]   drv_stat_nxt;
    genvar g;
    generate
        for (g = 0; g < N_ISCSI; g++)
        begin : g_iscsi
            assign iscsi_act_nxt[g] = sie_lamp(iscsi_link_up[g], iscsi_traffic[g], ph);
        end
        for (g = 0; g < N_FC; g++)
        begin : g_fc
            // rate code 0: 2G, 1: 4G, 2: 8G; missing module darkens both
            assign fc2_nxt[g] = fc_module_ok[g] & (fc_rate[2*g +: 2] != 2'h1);
            assign fc4_nxt[g] = fc_module_ok[g] & (fc_rate[2*g +: 2] != 2'h0);
        end
        for (g = 0; g < N_DRV; g++)
        begin : g_drv
            // failure outranks rebuild flashing
            assign drv_stat_nxt[g] = drive_failed[g] | (drive_rebuild[g] & ph);
        end
    endgenerate

    wire sys_err_nxt = psu_fault | ctrl_fault | (|drive_failed)
                     | enclosure_service_module_fault;
    wire [31:0] lamp_word = {14'h0, diag_led, heartbeat_led, encl_link_up_led,
                             encl_link_fault_led, sys_error_led, overtemp_led,
                             tengig_act_led, tengig_rate_led, batt_fault_led,
                             batt_charge_led, remove_ok_led, ctrl_fault_led, cache_led,
                             sas_link_led, sas_service_led, mgmt_act_led, mgmt_speed_led,
                             1'b0};
    wire [31:0] disp_word = {8'h0, 2'(seq_r), 2'h0, 4'(idx_r), 2'h0, seg_tens, seg_ones};
    wire [31:0] rd_nxt = (wb_adr_i == SIE_REG_CTRL)  ? ctrl_r
                       : (wb_adr_i == SIE_REG_DIV)   ? div_r
                       : (wb_adr_i == SIE_REG_ENCL)  ? encl_r
                       : (wb_adr_i == SIE_REG_EVCNT) ? evcnt_r
                       : (wb_adr_i == SIE_REG_LAMP)  ? lamp_word
                       : (wb_adr_i == SIE_REG_DISP)  ? disp_word
                       : evt_hit ? {16'h0, evt_r[evt_ix]} : 32'h0;

    // wishbone slave, one wait state, unmapped reads zero
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            ctrl_r   <= SIE_CTRL_RST;
            div_r    <= 32'(FLASH_DIV);
            encl_r   <= SIE_ENCL_RST;
            evcnt_r  <= SIE_EVCNT_RST;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_nxt : 32'h0;
            if (wb_wr && wb_adr_i == SIE_REG_CTRL)
                ctrl_r <= merge(ctrl_r, wb_dat_i, sel_mask);
            if (wb_wr && wb_adr_i == SIE_REG_DIV)
                div_r <= merge(div_r, wb_dat_i, sel_mask);
            if (wb_wr && wb_adr_i == SIE_REG_ENCL)
                encl_r <= merge(encl_r, wb_dat_i, sel_mask);
            if (wb_wr && wb_adr_i == SIE_REG_EVCNT)
                evcnt_r <= merge(evcnt_r, wb_dat_i, sel_mask);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            for (int i = 0; i < N_EVT; i++)
                evt_r[i] <= 16'h0;
        else if (wb_wr && evt_hit)
            evt_r[evt_ix] <= 16'(merge({16'h0, evt_r[evt_ix]}, wb_dat_i, sel_mask));
    end

    // sequencer holding each code for SIE_HOLD_TICKS ticks of the divider
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            seq_r  <= SIE_SQ_CAT;
            idx_r  <= '0;
            hold_r <= 3'h0;
        end
        else
        begin
            seq_r <= seq_nxt;
            idx_r <= idx_nxt;
            if (!boot_err || hold_end)
                hold_r <= 3'h0;
            else if (tick)
                hold_r <= hold_r + 3'h1;
        end
    end

    // registered lamp outputs
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            {mgmt_speed_led, mgmt_act_led, sas_service_led, sas_link_led} <= 4'h0;
            {cache_led, ctrl_fault_led, remove_ok_led} <= 3'h0;
            {batt_charge_led, batt_fault_led, tengig_rate_led, tengig_act_led} <= 4'h0;
            {overtemp_led, sys_error_led, encl_link_fault_led, encl_link_up_led} <= 4'h0;
            {diag_led, heartbeat_led} <= 2'h0;
            iscsi_act_led    <= '0;
            iscsi_speed_led  <= '0;
            fc_2g_led        <= '0;
            fc_4g_led        <= '0;
            drive_act_led    <= '0;
            drive_status_led <= '0;
            seg_tens         <= SIE_SEG_BLANK;
            seg_ones         <= SIE_SEG_BLANK;
        end
        else
        begin
            mgmt_speed_led   <= mgmt_link_up & mgmt_gig;
            mgmt_act_led     <= sie_lamp(mgmt_link_up, mgmt_traffic, ph);
            sas_service_led  <= sas_link_problem;
            sas_link_led     <= sie_lamp(sas_link_up, sas_traffic, ph);
            cache_led        <= cache_offload ? ph : (cache_backup_en & cache_has_data);
            ctrl_fault_led   <= ctrl_fault;
            remove_ok_led    <= ~io_active & ~cache_has_data & ~cache_offload;
            batt_charge_led  <= ~batt_no_hold & (batt_full | (batt_charging & ph));
            batt_fault_led   <= batt_no_hold;
            iscsi_act_led    <= iscsi_act_nxt;
            iscsi_speed_led  <= iscsi_link_up & iscsi_gig;
            fc_2g_led        <= fc2_nxt;
            fc_4g_led        <= fc4_nxt;
            tengig_rate_led  <= tengig_acquiring ? ph
                              : (tengig_link_up & tengig_rate_10g);
            tengig_act_led   <= sie_lamp(tengig_link_up, tengig_traffic, ph);
            drive_act_led    <= drive_active & {N_DRV{ph}};
            drive_status_led <= drv_stat_nxt;
            overtemp_led     <= overtemp;
            sys_error_led    <= sys_err_nxt;
            encl_link_fault_led <= ~enclosure_service_module_link_ok;
            encl_link_up_led   <= enclosure_service_module_link_ok;
            diag_led         <= ~running & ~blank;
            heartbeat_led    <= running & ph;
            seg_tens         <= tens_nxt;
            seg_ones         <= ones_nxt;
        end
    end
endmodule // sie_top
`default_nettype wire

//--- sie_top_assertions.sv
// concurrent checks of lamp and bus behaviour of the status encoder
`timescale 1ns/10ps
`default_nettype none
module sie_top_chk
#(
    parameter int N_FC  = 4,
    parameter int N_DRV = 12
)
(
    input wire logic             sys_clk, rstn, wb_cyc_i, wb_stb_i, wb_ack_o,
    input wire logic             mgmt_link_up, mgmt_gig, mgmt_speed_led, mgmt_act_led,
    input wire logic             sas_link_problem, sas_service_led, ctrl_fault, ctrl_fault_led,
    input wire logic             io_active, cache_has_data, remove_ok_led,
    input wire logic             batt_no_hold, batt_fault_led, batt_charge_led,
    input wire logic             overtemp, overtemp_led, psu_fault, sys_error_led,
    input wire logic             enclosure_service_module_fault,
    input wire logic             enclosure_service_module_link_ok,
    input wire logic             encl_link_up_led, encl_link_fault_led,
    input wire logic [N_FC-1:0]  fc_module_ok, fc_2g_led, fc_4g_led,
    input wire logic [2*N_FC-1:0] fc_rate,
    input wire logic [N_DRV-1:0] drive_failed
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_wb_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle after request");
    a_mgmt_speed: assert property (mgmt_link_up |=> mgmt_speed_led == $past(mgmt_gig))
        else $error("management speed lamp wrong");
    a_mgmt_dark: assert property (!mgmt_link_up |=> !mgmt_act_led)
        else $error("management activity lamp lit without link");
    a_sas_service: assert property (1'b1 |=> sas_service_led == $past(sas_link_problem))
        else $error("sas service lamp wrong");
    a_ctrl_fault: assert property (1'b1 |=> ctrl_fault_led == $past(ctrl_fault))
        else $error("controller fault lamp wrong");
    a_remove_block: assert property (io_active || cache_has_data |=> !remove_ok_led)
        else $error("removal lamp lit while busy");
    a_batt_fault: assert property (batt_no_hold
        |=> batt_fault_led && !batt_charge_led)
        else $error("battery lamps wrong on failed battery");
    a_overtemp_lamp: assert property (1'b1 |=> overtemp_led == $past(overtemp))
        else $error("over temperature lamp wrong");
    a_sys_error: assert property (psu_fault || ctrl_fault || (|drive_failed)
        || enclosure_service_module_fault |=> sys_error_led)
        else $error("system error lamp dark on fault");
    a_fc_speed: assert property (!fc_module_ok[0] |=> !fc_2g_led[0] && !fc_4g_led[0])
        else $error("fibre channel lamps lit without module");
    a_fc_eight: assert property (fc_module_ok[0] && fc_rate[1:0] == 2'h2
        |=> fc_2g_led[0] && fc_4g_led[0])
        else $error("fibre channel eight gig lamps wrong");
    a_encl_link: assert property (1'b1 |=> encl_link_fault_led == !encl_link_up_led
        && encl_link_up_led == $past(enclosure_service_module_link_ok))
        else $error("enclosure module link lamps wrong");

    c_bus: cover property (wb_cyc_i && wb_stb_i ##1 wb_ack_o);
    c_fault: cover property (psu_fault ##1 sys_error_led);
    c_fc: cover property (fc_module_ok[0] && fc_rate[1:0] == 2'h2);
endmodule // sie_top_chk

bind sie_top sie_top_chk #(.N_FC(N_FC), .N_DRV(N_DRV)) chk_u (.*);
`default_nettype wire

//--- sie_panel.sv
// panel model: records which levels each lamp took and the first eight display changes
`timescale 1ns/10ps
`default_nettype none
module sie_panel
(
    input wire logic        clk, clr,
    input wire logic [22:0] lamp,
    input wire logic [14:0] disp,
    output logic     [22:0] on, off
);
    logic [14:0] last, log_v [8];
    int          log_t [8];
    int          n_log, cyc_n;
    always @(posedge clk)
    begin
        cyc_n <= cyc_n + 1;
        last <= disp;
        if (clr)
        begin
            on <= '0;
            off <= '0;
            n_log <= 0;
        end
        else
        begin
            on <= on | lamp;
            off <= off | ~lamp;
            if (disp !== last && n_log < 8)
            begin
                log_v[n_log] <= disp;
                log_t[n_log] <= cyc_n;
                n_log <= n_log + 1;
            end
        end
    end
endmodule // sie_panel
`default_nettype wire

//--- status_indicator_encoder_test.sv
// testbench of the status indicator encoder
`timescale 1ns/10ps
`default_nettype none
module status_indicator_encoder_test;
    import sie_pkg::*;
    localparam int DIVV = 4;
    // table entry: status inputs, lamp index, expected {seen on, seen off}
    localparam logic [43:0] TBL [56] = '{
        44'h00000003_00_2, 44'h00000001_00_1, 44'h00000001_01_2, 44'h00000005_01_3,
        44'h00000000_01_1, 44'h00000008_02_2, 44'h00000000_02_1, 44'h00000010_03_2,
        44'h00000030_03_3, 44'h00000000_03_1, 44'h000000C0_04_2, 44'h000001C0_04_3,
        44'h00000000_04_1, 44'h00000200_05_2, 44'h00000000_05_1, 44'h00000000_06_2,
        44'h00000080_06_1, 44'h00000400_06_1, 44'h00000800_07_2, 44'h00001000_07_3,
        44'h00002000_07_1, 44'h00002000_08_2, 44'h00000000_08_1, 44'h00004000_09_2,
        44'h00014000_09_3, 44'h00000000_09_1, 44'h0000C000_0A_2, 44'h00004000_0A_1,
        44'h00020000_0B_2, 44'h00020000_0C_1, 44'h00060000_0B_1, 44'h00060000_0C_2,
        44'h000A0000_0B_2, 44'h000A0000_0C_2, 44'h00000000_0B_1, 44'h00000000_0C_1,
        44'h00300000_0D_2, 44'h00100000_0D_1, 44'h00500000_0D_3, 44'h00100000_0E_2,
        44'h00900000_0E_3, 44'h00000000_0E_1, 44'h01000000_0F_3, 44'h00000000_0F_1,
        44'h02000000_10_2, 44'h04000000_10_3, 44'h08000000_11_2, 44'h00000000_11_1,
        44'h10000000_12_2, 44'h20000000_12_2, 44'h02000000_12_2, 44'h00000000_12_1,
        44'h40000000_14_2, 44'h40000000_13_1, 44'h00000000_13_2, 44'h00000000_14_1};
    localparam logic [14:0] SEQ [7] = '{{1'b1, 7'h06, 7'h5B}, {1'b1, 7'h3F, 7'h4F},
        {1'b1, SIE_SEG_DASH, SIE_SEG_DASH}, {1'b1, 7'h66, 7'h6D}, {1'b1, 7'h3F, 7'h3F},
        {1'b0, SIE_SEG_BLANK, SIE_SEG_BLANK}, {1'b1, 7'h06, 7'h5B}};
    logic            sys_clk, rstn, cyc, stb, we, clr;
    logic [7:0]      adr;
    logic [3:0]      sel;
    logic [31:0]     dat, st, q;
    wire logic [31:0] dat_o;
    wire logic       ack;
    wire logic [22:0] lv, on_v, off_v;
    wire logic [3:0] iact, ispd, f2, f4;
    wire logic [11:0] dact, dst;
    wire logic [6:0] tens, ones;
    int              n_errors, compares;

    assign {lv[16], lv[15], lv[12], lv[11], lv[10], lv[9]} =
        {dst[0], dact[0], f4[0], f2[0], ispd[0], iact[0]};

    sie_top #(.FLASH_DIV(DIVV)) dut_u (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .mgmt_link_up(st[0]), .mgmt_gig(st[1]),
        .mgmt_traffic(st[2]), .sas_link_problem(st[3]), .sas_link_up(st[4]),
        .sas_traffic(st[5]), .cache_backup_en(st[6]), .cache_has_data(st[7]),
        .cache_offload(st[8]), .ctrl_fault(st[9]), .io_active(st[10]), .batt_full(st[11]),
        .batt_charging(st[12]), .batt_no_hold(st[13]), .iscsi_link_up({3'h0, st[14]}),
        .iscsi_gig({3'h0, st[15]}), .iscsi_traffic({3'h0, st[16]}),
        .fc_module_ok({3'h0, st[17]}), .fc_rate({6'h00, st[19:18]}),
        .tengig_link_up(st[20]), .tengig_rate_10g(st[21]), .tengig_acquiring(st[22]),
        .tengig_traffic(st[23]), .drive_active({11'h000, st[24]}),
        .drive_failed({11'h000, st[25]}), .drive_rebuild({11'h000, st[26]}),
        .overtemp(st[27]), .psu_fault(st[28]), .enclosure_service_module_fault(st[29]),
        .enclosure_service_module_link_ok(st[30]), .mgmt_speed_led(lv[0]),
        .mgmt_act_led(lv[1]), .sas_service_led(lv[2]), .sas_link_led(lv[3]),
        .cache_led(lv[4]), .ctrl_fault_led(lv[5]), .remove_ok_led(lv[6]),
        .batt_charge_led(lv[7]), .batt_fault_led(lv[8]), .iscsi_act_led(iact),
        .iscsi_speed_led(ispd), .fc_2g_led(f2), .fc_4g_led(f4), .tengig_rate_led(lv[13]),
        .tengig_act_led(lv[14]), .drive_act_led(dact), .drive_status_led(dst),
        .overtemp_led(lv[17]), .sys_error_led(lv[18]), .encl_link_fault_led(lv[19]),
        .encl_link_up_led(lv[20]), .diag_led(lv[21]), .heartbeat_led(lv[22]),
        .seg_tens(tens), .seg_ones(ones));
    sie_panel panel_u (.clk(sys_clk), .clr(clr), .lamp(lv), .disp({lv[21], tens, ones}),
        .on(on_v), .off(off_v));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hF};
        do @(posedge sys_clk); while (ack !== 1'b1);
        q = dat_o;
        {cyc, stb} <= 2'b00;
        @(posedge sys_clk);
    endtask

    // one lamp watched over three flash periods after the inputs settle
    task automatic lamp_chk(input logic [43:0] e);
        st <= e[43:12];
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        repeat (24) @(posedge sys_clk);
        chk({on_v[e[11:4]], off_v[e[11:4]]}, e[3:0]);
    endtask

    task automatic finish_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        finish_test;
    end

    initial
    begin
        rstn = 1'b0;
        {cyc, stb, we, clr} = 4'h0;
        {adr, sel, dat, st} = '0;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        wb(1'b0, SIE_REG_CTRL, 32'h0);
        chk(q, SIE_CTRL_RST);
        wb(1'b0, SIE_REG_DIV, 32'h0);
        chk(q, DIVV);
        wb(1'b0, SIE_REG_EVCNT, 32'h0);
        chk(q, SIE_EVCNT_RST);
        wb(1'b1, 8'h40, 32'hFFFF_FFFF);
        wb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        foreach (TBL[i]) lamp_chk(TBL[i]);
        wb(1'b1, SIE_REG_CTRL, 32'h0000_3700);
        repeat (3) @(posedge sys_clk);
        chk({lv[22:21], tens, ones}, {2'b01, 7'h4F, 7'h07});
        wb(1'b1, SIE_REG_EVT0, 32'h0000_0312);
        wb(1'b1, SIE_REG_EVT0 + 8'h04, 32'h0000_0045);
        wb(1'b1, SIE_REG_EVCNT, 32'h2);
        wb(1'b1, SIE_REG_CTRL, 32'h2);
        while (!(tens === 7'h00 && ones === 7'h00 && lv[21] === 1'b0))
            @(posedge sys_clk);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        repeat (250) @(posedge sys_clk);
        chk(panel_u.n_log >= 7, 32'h1);
        for (int i = 0; i < 7; i++) chk(panel_u.log_v[i], SEQ[i]);
        chk(panel_u.log_t[1] - panel_u.log_t[0], SIE_HOLD_TICKS * DIVV);
        wb(1'b1, SIE_REG_ENCL, 32'h5A);
        wb(1'b1, SIE_REG_CTRL, 32'h1);
        repeat (3) @(posedge sys_clk);
        chk({lv[21], tens, ones}, {1'b0, 7'h6D, 7'h77});
        wb(1'b0, SIE_REG_DISP, 32'h0);
        chk(q, {18'h0, 7'h6D, 7'h77});
        lamp_chk({32'h0, 8'h16, 4'h3});
        lamp_chk({32'h0, 8'h15, 4'h1});
        finish_test;
    end
endmodule // status_indicator_encoder_test
`default_nettype wire
